// file: dv/rom_model.sv
// external program rom that answers on the port pins
`timescale 1ns/10ps
`default_nettype none
module rom_model (
  input wire logic ref_clk,
  input wire logic muxed,
  input wire logic [7:0] zero_out,
  input wire logic [7:0] one_out,
  input wire logic [7:0] two_out,
  input wire logic [7:0] four_out,
  input wire logic latch_out,
  input wire logic read_out,
  input wire logic read_oe,
  output logic [7:0] zero_in
);
  // ---------------------------------------------------------------
  // address decode and read data
  // ---------------------------------------------------------------
  logic [7:0] low_addr = 8'h00; // external latch contents
  logic [7:0] last = 8'hA5; // last byte put on the bus
  logic [19:0] addr; // address seen by the rom
  logic reading; // read strobe driven and low
  // low byte caught as the strobe falls, so it must still be valid then
  always @(negedge latch_out) begin
    low_addr <= zero_out;
  end
  assign addr = muxed ? {two_out[3:0], one_out, low_addr}
                      : {four_out[3:0], two_out, one_out};
  assign reading = read_oe && !read_out;
  // remember the byte so a released bus shows its inverse, not a stale copy
  always @(posedge ref_clk) begin
    if (reading) begin
      last <= zero_in;
    end
  end
  assign zero_in = reading ? (addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]} ^ 8'h5A) : ~last;
endmodule : rom_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the program-fetch port selector
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fetch_port_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, bus_style_strap = 1'b0, external_access_pin_n = 1'b0;
  logic break_instruction = 1'b0, watchdog_overflow = 1'b0, opcode_trap = 1'b0;
  logic sw_wr = 1'b0, fetch_req = 1'b0, muxed_state, fetch_ready, fetch_done, fetch_external;
  logic [5:0] sw_ctl = 6'h00, sw_mode = 6'h00, ctl_state, mode_state;
  logic [19:0] fetch_addr = 20'h00000, a;
  logic [7:0] fetch_data, port_zero_in, port_zero_out, port_zero_oe, port_one_out, port_one_oe;
  logic [7:0] io_out_zero, io_oe_zero, io_out_one, io_oe_one, io_out_two, io_oe_two;
  logic [7:0] io_out_four, io_oe_four, port_two_out, port_two_oe, port_four_out, port_four_oe;
  logic [1:0] io_out_three, io_oe_three;
  logic port_three_bit_zero_out, port_three_bit_zero_oe, port_three_bit_one_out;
  logic port_three_bit_one_oe;
  logic [31:0] s1, s5; // pin snapshots in address and read phases
  int error_cnt = 0, n_tests = 0, n;
  always #5 ref_clk = ~ref_clk;
  program_fetch_bus_port_select i_program_fetch_bus_port_select (.ref_clk, .rst,
    .bus_style_strap, .external_access_pin_n, .break_instruction, .watchdog_overflow,
    .opcode_trap, .sw_wr, .sw_ctl, .sw_mode, .ctl_state, .mode_state, .muxed_state,
    .fetch_req, .fetch_addr, .fetch_ready, .fetch_done, .fetch_data, .fetch_external,
    .io_out_zero, .io_oe_zero, .io_out_one, .io_oe_one, .io_out_two, .io_oe_two,
    .io_out_four, .io_oe_four, .io_out_three, .io_oe_three, .port_zero_in, .port_zero_out,
    .port_zero_oe, .port_one_out, .port_one_oe, .port_two_out, .port_two_oe,
    .port_four_out, .port_four_oe, .port_three_bit_zero_out, .port_three_bit_zero_oe,
    .port_three_bit_one_out, .port_three_bit_one_oe);
  rom_model i_rom_model (.ref_clk, .muxed(!bus_style_strap), .zero_out(port_zero_out),
    .one_out(port_one_out), .two_out(port_two_out), .four_out(port_four_out),
    .latch_out(port_three_bit_zero_out), .read_out(port_three_bit_one_out),
    .read_oe(port_three_bit_one_oe), .zero_in(port_zero_in));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte the rom holds at an address
  function automatic logic [7:0] exp_byte(input logic [19:0] x);
    return x[7:0] ^ x[15:8] ^ {4'h0, x[19:16]} ^ 8'h5A;
  endfunction : exp_byte
  // one comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // reset with straps, then let the init cycle pass
  task automatic do_reset(input logic strap, input logic pin_n);
    rst = 1'b1;
    bus_style_strap = strap;
    external_access_pin_n = pin_n;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : do_reset
  // one-cycle pulse on a reset source or the software write
  task automatic pulse(input int k, input logic [5:0] c);
    sw_ctl = c;
    sw_mode = c;
    {opcode_trap, watchdog_overflow, break_instruction, sw_wr} = 4'(1 << k);
    @(posedge ref_clk);
    #1 {opcode_trap, watchdog_overflow, break_instruction, sw_wr} = 4'h0;
    // idle edge, so a following pulse never re-raises a strobe in this time step
    @(posedge ref_clk);
    #1;
  endtask : pulse
  // one fetch; n is edges from taking edge to the done pulse
  task automatic fetch(input logic [19:0] x);
    int w;
    fetch_addr = x;
    fetch_req = 1'b1;
    w = 0;
    while (fetch_ready !== 1'b1 && w < 50) begin
      @(posedge ref_clk);
      #1 w++;
    end
    if (w == 50) begin
      error_cnt++;
      summarize();
    end
    @(posedge ref_clk);
    #1 fetch_req = 1'b0;
    for (n = 1; n < 30 && fetch_done !== 1'b1; n++) begin
      if (n == 1) s1 = {port_zero_oe, port_one_out, port_two_out, 7'h00, port_three_bit_zero_out};
      if (n == 5) s5 = {port_zero_oe, 23'h0, port_three_bit_one_out};
      @(posedge ref_clk);
      #1;
    end
    // a fetch that never answers is a mismatch and ends the run
    if (n == 30) begin
      error_cnt++;
      summarize();
    end
  endtask : fetch
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(95477));
    {io_out_zero, io_oe_zero, io_out_one, io_oe_one} = $urandom;
    {io_out_two, io_oe_two, io_out_four, io_oe_four} = $urandom;
    {io_out_three, io_oe_three} = 4'($urandom);
    // multiplexed, all program external
    do_reset(1'b0, 1'b0);
    check(muxed_state, 1);
    check({ctl_state, mode_state}, {MUX_AUTO, MUX_AUTO});
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 20'h00000 : (i == 1) ? 20'hFFFFF : 20'($urandom);
      fetch(a);
      check(n, 9);
      check(fetch_external, 1);
      check(fetch_data, exp_byte(a));
      check(s1, {8'hFF, a[15:8], 4'h0, a[19:16], 8'h01});
      check(s5, 32'h0);
      check({port_three_bit_zero_oe, port_three_bit_one_oe}, 2'b11);
    end
    // soft reset sources reload the bus setting after software cleared it
    for (int k = 1; k < 4; k++) begin
      pulse(0, 6'h00);
      check(ctl_state, 0);
      pulse(k, 6'h00);
      check({ctl_state, mode_state}, {MUX_AUTO, MUX_AUTO});
    end
    // port one handed back to plain I/O while still fetching externally
    pulse(0, 6'h35);
    a = 20'($urandom);
    fetch(a);
    check(fetch_data, exp_byte({a[19:16], io_out_one, a[7:0]}));
    check({port_one_out, port_one_oe}, {io_out_one, io_oe_one});
    // access pin high: internal below the boundary, external from it
    do_reset(1'b0, 1'b1);
    check(ctl_state, 0);
    fetch(EXT_BASE);
    check(fetch_external, 1);
    check({port_one_out, port_two_out}, {io_out_one, io_out_two});
    pulse(0, MUX_AUTO);
    a = EXT_BASE | 20'($urandom % 32'h20000);
    fetch(a);
    check(fetch_data, exp_byte(a));
    // internal fetch after bus ports were set must still leave them as I/O
    fetch(INT_TOP);
    check({n[15:0], 7'h0, fetch_external, fetch_data}, {16'd2, 16'h0});
    check({port_zero_oe, port_one_out}, {io_oe_zero, io_out_one});
    // separate bus, all external
    do_reset(1'b1, 1'b0);
    check({muxed_state, ctl_state}, {1'b0, SEP_AUTO});
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 20'hFFFFF : 20'($urandom);
      fetch(a);
      check({n[23:0], fetch_data}, {24'd6, exp_byte(a)});
      check({port_zero_oe, port_two_oe, port_four_oe, fetch_ready}, {16'h00FF, 8'hFF, 1'b1});
      check({port_one_out, port_four_out}, {a[7:0], 4'h0, a[19:16]});
    end
    // separate bus, internal fetch leaves the ports alone
    do_reset(1'b1, 1'b1);
    pulse(0, SEP_AUTO);
    fetch(EXT_BASE | 20'($urandom % 32'h20000));
    fetch(20'($urandom % 32'h20000));
    check({fetch_external, port_four_out, port_four_oe}, {1'b0, io_out_four, io_oe_four});
    summarize();
  end
endmodule : tb_top
`default_nettype wire

// file: include/fetch_if.sv
// interface: selector to bus-cycle sequencer signals
`timescale 1ns/10ps
`default_nettype none
interface fetch_if;
  logic start;                 // begin one external fetch
  logic muxed;                 // multiplexed bus style
  logic [7:0] data_in;         // port zero pin levels
  logic busy;                  // sequencer not idle
  logic ale;                   // latch strobe, active high
  logic read_n;                // read strobe, active low
  logic drive_low_addr;        // port zero carries address
  logic done;                  // last cycle of the fetch
  logic [7:0] data;            // captured program byte

  modport ctl (output start, output muxed, output data_in,
               input busy, input ale, input read_n, input drive_low_addr,
               input done, input data);
  modport seq (input start, input muxed, input data_in,
               output busy, output ale, output read_n, output drive_low_addr,
               output done, output data);
endinterface : fetch_if
`default_nettype wire

// file: include/fetch_port_pkg.sv
// package: constants and types for the program-fetch port selector
// ---------------------------------------------------------------
// Functional notes
// R1: strap low selects multiplexed address/data bus
// R2: internal fetch with access pin high keeps I/O
// R3: external fetch: all if pin low, else from 20000H
// R4: port zero drives low address, then reads data
// R5: ports one and two drive upper address bits
// R6: bit zero latch strobe, bit one read strobe
// R7: pin low: every reset source enables bus functions
// R8: pin high: software enables bus before external fetch
// R9: cleared port control returns that port to I/O
// R10: separate bus, pin low: whole range fetched externally
// R11: separate bus, internal fetch keeps ports as I/O
// R12: latch strobe ends before port zero turns around
// ---------------------------------------------------------------
package fetch_port_pkg;

  // -------------------------------------------------------------
  // address space
  // -------------------------------------------------------------
  localparam int ADDR_W = 20;                        // 1 MB program space
  localparam logic [19:0] INT_TOP = 20'h1FFFF;       // last internal address
  localparam logic [19:0] EXT_BASE = 20'h20000;      // first external address
  localparam logic [19:0] ADDR_MAX = 20'hFFFFF;      // top of program space

  // -------------------------------------------------------------
  // bit positions in the control and mode vectors
  // -------------------------------------------------------------
  localparam int PORT_BITS = 6;
  localparam int PB_ZERO = 0;                        // port zero
  localparam int PB_ONE = 1;                         // port one
  localparam int PB_TWO = 2;                         // port two
  localparam int PB_FOUR = 3;                        // port four
  localparam int PB_LATCH = 4;                       // port three bit zero
  localparam int PB_READ = 5;                        // port three bit one

  // -------------------------------------------------------------
  // values after reset
  // -------------------------------------------------------------
  localparam logic [5:0] CTL_RESET = 6'h00;          // everything plain I/O
  localparam logic [5:0] MUX_AUTO = 6'h37;           // zero, one, two, latch, read
  localparam logic [5:0] SEP_AUTO = 6'h2F;           // zero, one, two, four, read

  // -------------------------------------------------------------
  // bus cycle timing
  // -------------------------------------------------------------
  localparam int CLK_NS = 10;                        // 100 MHz core clock
  localparam int ALE_NS = 20;                        // latch strobe width
  localparam int HOLD_NS = 10;                       // address hold after strobe
  localparam int READ_NS = 40;                       // read strobe width
  localparam logic [3:0] ALE_CYC = 4'((ALE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] READ_CYC = 4'((READ_NS + CLK_NS - 1) / CLK_NS);

  // phases of one external fetch
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_HOLD, PH_READ, PH_DONE} phase_t;

endpackage : fetch_port_pkg

// file: verilog/fetch_sequencer.sv
// module: strobe and turnaround sequence of one external program fetch
`timescale 1ns/10ps
`default_nettype none
module fetch_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  fetch_if.seq bus
);
  import fetch_port_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  phase_t state;               // current phase
  phase_t next_state;
  logic [3:0] cnt;             // cycles left in phase after this one
  logic [3:0] next_cnt;
  logic [7:0] data;            // captured byte
  logic [7:0] next_data;

  // next phase; separate bus skips the address latch phases
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_data = data;
    case (state)
      PH_IDLE: begin
        if (bus.start && bus.muxed) begin
          next_state = PH_ADDR;                  // see R4
          next_cnt = ALE_CYC - 4'h1;
        end else if (bus.start) begin
          next_state = PH_READ;                  // see R10
          next_cnt = READ_CYC - 4'h1;
        end
      end
      PH_ADDR: begin
        if (cnt == 4'h0) begin
          next_state = PH_HOLD;                  // see R12
          next_cnt = HOLD_CYC - 4'h1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PH_HOLD: begin
        if (cnt == 4'h0) begin
          next_state = PH_READ;
          next_cnt = READ_CYC - 4'h1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PH_READ: begin
        if (cnt == 4'h0) begin
          next_state = PH_DONE;
          next_data = bus.data_in;               // sample at strobe end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      PH_DONE: next_state = PH_IDLE;
      default: next_state = PH_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= PH_IDLE;
      cnt <= 4'h0;
      data <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      data <= next_data;
    end
  end

  // strobes decoded from registered state, so they cannot glitch
  assign bus.busy = (state != PH_IDLE);
  assign bus.ale = (state == PH_ADDR);                               // see R6
  assign bus.read_n = (state != PH_READ);                            // see R6
  assign bus.drive_low_addr = (state == PH_ADDR) || (state == PH_HOLD); // see R4
  assign bus.done = (state == PH_DONE);
  assign bus.data = data;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_ale_before_read: assert property (bus.ale ##1 !bus.ale // see R12
    |-> bus.read_n && bus.drive_low_addr)
    else $error("latch strobe did not end before the read phase");
  a_read_strobe_len: assert property ($fell(bus.read_n) // see R6
    |-> !bus.read_n [*4] ##1 bus.read_n)
    else $error("read strobe width wrong");
  a_no_addr_in_read: assert property (!bus.read_n |-> !bus.drive_low_addr) // see R4
    else $error("port zero drives address while reading");
  c_mux_fetch: cover property (bus.start && bus.muxed ##1 bus.ale ##[1:20] bus.done);
  c_sep_fetch: cover property (bus.start && !bus.muxed ##[1:20] bus.done);
endmodule : fetch_sequencer
`default_nettype wire

// file: verilog/program_fetch_bus_port_select.sv
// module: port role selection between plain I/O and external program bus
`timescale 1ns/10ps
`default_nettype none
module program_fetch_bus_port_select (
  input wire logic ref_clk,
  input wire logic rst,                    // reset pin, async
  input wire logic bus_style_strap,        // low: multiplexed bus
  input wire logic external_access_pin_n,  // low: all program external
  input wire logic break_instruction,      // reset source pulse
  input wire logic watchdog_overflow,      // reset source pulse
  input wire logic opcode_trap,            // reset source pulse
  input wire logic sw_wr,                  // software write pulse
  input wire logic [fetch_port_pkg::PORT_BITS-1:0] sw_ctl,
  input wire logic [fetch_port_pkg::PORT_BITS-1:0] sw_mode,
  output logic [fetch_port_pkg::PORT_BITS-1:0] ctl_state,
  output logic [fetch_port_pkg::PORT_BITS-1:0] mode_state,
  output logic muxed_state,
  input wire logic fetch_req,
  input wire logic [fetch_port_pkg::ADDR_W-1:0] fetch_addr,
  output logic fetch_ready,
  output logic fetch_done,
  output logic [7:0] fetch_data,
  output logic fetch_external,
  input wire logic [7:0] io_out_zero,
  input wire logic [7:0] io_oe_zero,
  input wire logic [7:0] io_out_one,
  input wire logic [7:0] io_oe_one,
  input wire logic [7:0] io_out_two,
  input wire logic [7:0] io_oe_two,
  input wire logic [7:0] io_out_four,
  input wire logic [7:0] io_oe_four,
  input wire logic [1:0] io_out_three,
  input wire logic [1:0] io_oe_three,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_zero_oe,
  output logic [7:0] port_one_out,
  output logic [7:0] port_one_oe,
  output logic [7:0] port_two_out,
  output logic [7:0] port_two_oe,
  output logic [7:0] port_four_out,
  output logic [7:0] port_four_oe,
  output logic port_three_bit_zero_out,
  output logic port_three_bit_zero_oe,
  output logic port_three_bit_one_out,
  output logic port_three_bit_one_oe
);
  import fetch_port_pkg::*;

  // external when the access pin is low or above the internal range
  function automatic logic is_external(input logic [19:0] addr, input logic ea_n);
    is_external = !ea_n || (addr >= EXT_BASE); // see R3
  endfunction : is_external

  // ---------------------------------------------------------------
  // secondary-function control and mode
  // ---------------------------------------------------------------
  logic init;                  // first cycle after reset release
  logic next_init;
  logic muxed;                 // caught bus style
  logic next_muxed;
  logic [5:0] ctl;             // secondary-function control
  logic [5:0] next_ctl;
  logic [5:0] mode;            // output mode
  logic [5:0] next_mode;
  logic [5:0] auto_set;        // bus set for the caught style
  logic any_src;               // a soft reset source fired
  logic [5:0] fn;              // port runs its bus function

  assign any_src = break_instruction || watchdog_overflow || opcode_trap;

  // pins are caught one edge after release, never under async reset
  always_comb begin
    next_init = 1'b0;
    next_muxed = muxed;
    next_ctl = ctl;
    next_mode = mode;
    auto_set = CTL_RESET;
    if (init || any_src) begin
      next_muxed = !bus_style_strap;                  // see R1
      auto_set = next_muxed ? MUX_AUTO : SEP_AUTO;
      if (!external_access_pin_n) begin
        next_ctl = auto_set;                          // see R7
        next_mode = auto_set;
      end else begin
        next_ctl = CTL_RESET;                         // leave as I/O
        next_mode = CTL_RESET;
      end
    end else if (sw_wr) begin
      next_ctl = sw_ctl;                              // see R9
      next_mode = sw_mode;
    end
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      init <= 1'b1;
      muxed <= 1'b1;
      ctl <= CTL_RESET;
      mode <= CTL_RESET;
    end else begin
      init <= next_init;
      muxed <= next_muxed;
      ctl <= next_ctl;
      mode <= next_mode;
    end
  end

  assign fn = ctl & mode;      // both must be set for a bus role
  assign ctl_state = ctl;
  assign mode_state = mode;
  assign muxed_state = muxed;

  // ---------------------------------------------------------------
  // fetch acceptance
  // ---------------------------------------------------------------
  fetch_if fbus ();
  fetch_sequencer u_seq (.ref_clk(ref_clk), .rst(rst), .bus(fbus));

  logic [19:0] cur_addr;       // address of the running fetch
  logic [19:0] next_cur_addr;
  logic next_ext;
  logic ipend;                 // internal fetch answered next edge
  logic next_ipend;
  logic next_done;
  logic [7:0] next_data;
  logic accept;
  logic ext_now;

  assign fetch_ready = !fbus.busy && !ipend && !init;
  assign accept = fetch_req && fetch_ready;
  assign ext_now = is_external(fetch_addr, external_access_pin_n);
  assign fbus.start = accept && ext_now;
  assign fbus.muxed = muxed;
  assign fbus.data_in = port_zero_in;

  // internal fetches are only acknowledged; the pins stay untouched
  always_comb begin
    next_cur_addr = cur_addr;
    next_ext = fetch_external;
    next_ipend = 1'b0;
    next_done = fbus.done || ipend;
    next_data = fbus.done ? fbus.data : 8'h00;
    if (accept) begin
      next_cur_addr = fetch_addr;
      next_ext = ext_now;                             // see R3
      next_ipend = !ext_now;                          // see R2
    end
  end

  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_addr <= 20'h00000;
      fetch_external <= 1'b0;
      ipend <= 1'b0;
      fetch_done <= 1'b0;
      fetch_data <= 8'h00;
    end else begin
      cur_addr <= next_cur_addr;
      fetch_external <= next_ext;
      ipend <= next_ipend;
      fetch_done <= next_done;
      fetch_data <= next_data;
    end
  end

  // ---------------------------------------------------------------
  // pin roles
  // ---------------------------------------------------------------
  logic [5:0] bus_on;          // bus role active for this fetch

  // an internal fetch leaves every port to the I/O side
  assign bus_on = fetch_external ? fn : CTL_RESET;    // see R2 R11

  always_comb begin
    port_zero_out = io_out_zero;
    port_zero_oe = io_oe_zero;
    port_one_out = io_out_one;
    port_one_oe = io_oe_one;
    port_two_out = io_out_two;
    port_two_oe = io_oe_two;
    port_four_out = io_out_four;
    port_four_oe = io_oe_four;
    port_three_bit_zero_out = io_out_three[0];
    port_three_bit_zero_oe = io_oe_three[0];
    port_three_bit_one_out = io_out_three[1];
    port_three_bit_one_oe = io_oe_three[1];
    if (muxed) begin
      if (bus_on[PB_ZERO]) begin
        port_zero_out = cur_addr[7:0];                // see R4
        port_zero_oe = {8{fbus.drive_low_addr}};      // released to read data
      end
      if (bus_on[PB_ONE]) begin
        port_one_out = cur_addr[15:8];                // see R5
        port_one_oe = 8'hFF;
      end
      if (bus_on[PB_TWO]) begin
        port_two_out = {4'h0, cur_addr[19:16]};       // see R5
        port_two_oe = 8'hFF;
      end
      if (bus_on[PB_LATCH]) begin
        port_three_bit_zero_out = fbus.ale;           // see R6 R12
        port_three_bit_zero_oe = 1'b1;
      end
    end else begin
      if (bus_on[PB_ZERO]) begin
        port_zero_oe = 8'h00;                         // see R10
      end
      if (bus_on[PB_ONE]) begin
        port_one_out = cur_addr[7:0];                 // see R10
        port_one_oe = 8'hFF;
      end
      if (bus_on[PB_TWO]) begin
        port_two_out = cur_addr[15:8];
        port_two_oe = 8'hFF;
      end
      if (bus_on[PB_FOUR]) begin
        port_four_out = {4'h0, cur_addr[19:16]};
        port_four_oe = 8'hFF;
      end
    end
    if (bus_on[PB_READ]) begin
      port_three_bit_one_out = fbus.read_n;           // see R6 R10
      port_three_bit_one_oe = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_auto_bus_set: assert property (init && !external_access_pin_n && !bus_style_strap // see R7
    |=> ctl_state == MUX_AUTO && mode_state == MUX_AUTO)
    else $error("bus functions not set after reset");
  a_style_strap: assert property (init |=> muxed_state == !$past(bus_style_strap)) // see R1
    else $error("bus style not taken from strap");
  a_fetch_decode: assert property (accept |=> fetch_external == // see R3
    (!$past(external_access_pin_n) || $past(fetch_addr) >= EXT_BASE))
    else $error("external decode wrong");
  a_internal_io: assert property (accept && external_access_pin_n // see R2
    && fetch_addr <= INT_TOP |=> port_one_oe == io_oe_one
    && port_three_bit_one_out == io_out_three[1])
    else $error("internal fetch moved a port off I/O");
  a_sep_internal: assert property (!muxed && !fetch_external // see R11
    |-> port_four_oe == io_oe_four)
    else $error("separate bus port left I/O on internal fetch");
  a_sep_full_range: assert property (accept && !external_access_pin_n // see R10
    |=> fetch_external)
    else $error("access pin low fetch not external");
  a_upper_addr: assert property (muxed && fetch_external && fn[PB_ONE] // see R5
    |-> port_one_oe == 8'hFF && port_one_out == cur_addr[15:8])
    else $error("upper address not driven");
  a_low_turnaround: assert property (muxed && fetch_external && fn[PB_ZERO] // see R4
    && !fbus.read_n |-> port_zero_oe == 8'h00)
    else $error("port zero still driving during read");
  a_cleared_io: assert property (!ctl_state[PB_TWO] |-> port_two_out == io_out_two) // see R9
    else $error("cleared port not back to I/O");
  a_strobe_pins: assert property (muxed && fetch_external && fn[PB_LATCH] // see R6
    && fn[PB_READ] |-> port_three_bit_zero_out == fbus.ale
    && port_three_bit_one_out == fbus.read_n)
    else $error("strobe pins not carrying strobes");
  c_internal: cover property (accept && !ext_now ##1 ipend ##1 fetch_done);
  c_sw_clear: cover property (sw_wr && !sw_ctl[PB_TWO] && ctl_state[PB_TWO]);
endmodule : program_fetch_bus_port_select
`default_nettype wire
